/* verilog/fcp_pkg.sv */
package fcp_pkg;
  // ****************************************************************
  // command codes and decode masks
  // ****************************************************************
  localparam logic [7:0] OP_SENSE_INT  = 8'h08;
  localparam logic [7:0] OP_SPECIFY    = 8'h03;
  localparam logic [7:0] OP_SENSE_DRV  = 8'h04;
  localparam logic [7:0] OP_SEEK       = 8'h0F;
  localparam logic [7:0] OP_REL_SEEK   = 8'h8F;
  localparam logic [7:0] OP_CONFIGURE  = 8'h13;
  localparam logic [7:0] OP_DUMP       = 8'h0E;
  localparam logic [7:0] OP_READ_ID    = 8'h0A;
  localparam logic [7:0] OP_PERP       = 8'h12;
  localparam logic [7:0] OP_LOCK       = 8'h14;
  localparam logic [7:0] MASK_DIR_MFM  = 8'hBF;
  localparam logic [7:0] MASK_LOCK     = 8'h7F;
  // ****************************************************************
  // field positions and fixed values
  // ****************************************************************
  localparam int         BIT_DIR       = 6;
  localparam int         BIT_LOCK      = 7;
  localparam int         BIT_LOCK_ECHO = 4;
  localparam int         BIT_SEEK_END  = 5;
  localparam int         BIT_HEAD      = 2;
  localparam logic [7:0] ST0_INVALID   = 8'h80;
  localparam logic [1:0] IC_NORMAL     = 2'b00;
  localparam logic [1:0] IC_ABNORMAL   = 2'b01;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam int         RES_DEPTH     = 10;
  localparam int         PRM_DEPTH     = 3;
  localparam int         NUM_DRIVES    = 4;
  localparam logic [3:0] RES_SENSE_INT = 4'h2;
  localparam logic [3:0] RES_ONE       = 4'h1;
  localparam logic [3:0] RES_READ_ID   = 4'h7;
  localparam logic [3:0] RES_DUMP      = 4'hA;

  typedef enum logic [3:0] {
    CMD_INVALID, CMD_SENSE_INT, CMD_SPECIFY, CMD_SENSE_DRV, CMD_SEEK,
    CMD_REL_SEEK, CMD_CONFIGURE, CMD_DUMP, CMD_READ_ID, CMD_PERP, CMD_LOCK
  } fcp_cmd_t;

  typedef enum logic [1:0] {ST_IDLE, ST_PARAM, ST_EXEC, ST_RESULT} fcp_state_t;

  // sector id plus status as delivered by the read channel
  typedef struct packed {
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } fcp_id_t;

  typedef struct packed {
    logic [7:0] specA;
    logic [7:0] specB;
    logic [7:0] cfgByte;
    logic [7:0] preTrk;
    logic [7:0] perp;
    logic       lock;
  } fcp_cfg_t;
endpackage

/* verilog/fcp_command_phases.sv */
`timescale 1ns/1ns
module fcp_command_phases
  import fcp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       cmdWrite,
  input  wire logic [7:0] cmdData,
  input  wire logic       resultRead,
  output logic      [7:0] resultByte,
  output logic            resultValid,
  output logic            cmdReady,
  output logic            standby,
  output logic            seekReq,
  output logic      [7:0] seekCyl,
  output logic      [1:0] seekDrive,
  input  wire logic       seekDone,
  input  wire logic       seekOk,
  input  wire logic [7:0] driveState,
  output logic            readIdReq,
  input  wire logic       idValid,
  input  wire fcp_id_t    idInfo,
  input  wire logic       xferStart,
  input  wire logic [1:0] xferDrive,
  input  wire logic [7:0] xferCyl,
  input  wire logic       xferDone,
  input  wire logic       xferWasFormat,
  input  wire logic [7:0] xferScEot,
  output logic            impliedSeekEn
);
  // ****************************************************************
  // decode
  // ****************************************************************
  function automatic fcp_cmd_t decodeOp(input logic [7:0] b);
    fcp_cmd_t c;
    c = CMD_INVALID;
    if (b == OP_SENSE_INT) c = CMD_SENSE_INT;
    else if (b == OP_SPECIFY) c = CMD_SPECIFY;
    else if (b == OP_SENSE_DRV) c = CMD_SENSE_DRV;
    else if (b == OP_SEEK) c = CMD_SEEK;
    else if ((b & MASK_DIR_MFM) == OP_REL_SEEK) c = CMD_REL_SEEK;
    else if (b == OP_CONFIGURE) c = CMD_CONFIGURE;
    else if (b == OP_DUMP) c = CMD_DUMP;
    else if ((b & MASK_DIR_MFM) == OP_READ_ID) c = CMD_READ_ID;
    else if (b == OP_PERP) c = CMD_PERP;
    else if ((b & MASK_LOCK) == OP_LOCK) c = CMD_LOCK;
    return c;
  endfunction

  function automatic logic [1:0] paramCount(input fcp_cmd_t c);
    logic [1:0] n;
    n = 2'd0;
    case (c)
      CMD_SENSE_DRV, CMD_READ_ID, CMD_PERP: n = 2'd1;
      CMD_SPECIFY, CMD_SEEK, CMD_REL_SEEK:  n = 2'd2;
      CMD_CONFIGURE:                        n = 2'd3;
      default:                              n = 2'd0;
    endcase
    return n;
  endfunction

  fcp_state_t state;
  fcp_cmd_t   cmd;
  logic [7:0] opByte;
  logic [7:0] prm [PRM_DEPTH];
  logic [1:0] prmIdx;
  logic [7:0] res [RES_DEPTH];
  logic [3:0] resIdx;
  logic [3:0] resCount;
  logic [7:0] current_cylinder_position [NUM_DRIVES];
  fcp_cfg_t   cfg;
  logic [7:0] scEot;
  logic [7:0] intSt0;
  logic       intPending;
  logic [1:0] selDrive;
  logic       selHead;

  wire fcp_cmd_t   newCmd    = decodeOp(cmdData);
  wire logic [1:0] newParams = paramCount(newCmd);
  wire logic       takeCmd   = (state == ST_IDLE) && cmdWrite;
  wire logic       takePrm   = (state == ST_PARAM) && cmdWrite;
  wire logic       lastPrm   = takePrm && (prmIdx == paramCount(cmd) - 2'd1);
  wire logic       lastRes   = (state == ST_RESULT) && resultRead && (resIdx == resCount - 4'd1);
  // drive select from the first parameter byte, kept inside the block
  wire logic [1:0] prmDrive  = prm[0][1:0];
  wire logic [7:0] relTarget = opByte[BIT_DIR] ? current_cylinder_position[prmDrive] + cmdData
                                               : current_cylinder_position[prmDrive] - cmdData;
  wire logic       needSeek  = cfg.cfgByte[BIT_DIR] && xferStart && (xferCyl != current_cylinder_position[xferDrive]);
  wire logic       intClear  = (state == ST_EXEC) && (cmd == CMD_SENSE_INT) && intPending;
  wire logic [7:0] lockEcho  = 8'(cfg.lock) << BIT_LOCK_ECHO;
  wire logic [7:0] seekSt0   = {seekOk ? IC_NORMAL : IC_ABNORMAL, 1'b1, 2'b00,
                                selHead, selDrive};

  // ****************************************************************
  // phase sequencing
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state  <= ST_IDLE;
      cmd    <= CMD_INVALID;
      opByte <= BYTE_ZERO;
      prmIdx <= 2'd0;
      resIdx <= 4'd0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (takeCmd)
          begin
            cmd    <= newCmd;
            opByte <= cmdData;
            prmIdx <= 2'd0;
            state  <= (newParams == 2'd0) ? ST_EXEC : ST_PARAM;
          end
        ST_PARAM:
          if (takePrm)
          begin
            prmIdx <= prmIdx + 2'd1;
            if (lastPrm)
              state <= ST_EXEC;
          end
        ST_EXEC:
          if (!(cmd == CMD_READ_ID && !idValid))
          begin
            resIdx <= 4'd0;
            state  <= (resCount != 4'd0 || cmd != CMD_SPECIFY) ? ST_RESULT : ST_IDLE;
            if (cmd inside {CMD_SPECIFY, CMD_SEEK, CMD_REL_SEEK, CMD_CONFIGURE, CMD_PERP})
              state <= ST_IDLE;
          end
        ST_RESULT:
          if (resultRead)
          begin
            resIdx <= resIdx + 4'd1;
            if (lastRes)
              state <= ST_IDLE;
          end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (takePrm)
      prm[prmIdx] <= cmdData;
  end

  // ****************************************************************
  // execution: settings, seeks, result buffer
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cfg        <= '0;
      scEot      <= BYTE_ZERO;
      intSt0     <= BYTE_ZERO;
      intPending <= 1'b0;
      selDrive   <= 2'd0;
      selHead    <= 1'b0;
      seekReq    <= 1'b0;
      seekCyl    <= BYTE_ZERO;
      seekDrive  <= 2'd0;
      readIdReq  <= 1'b0;
      standby    <= 1'b0;
      resCount   <= 4'd0;
      for (int i = 0; i < NUM_DRIVES; i++)
        current_cylinder_position[i] <= BYTE_ZERO;
    end
    else
    begin
      seekReq   <= 1'b0;
      readIdReq <= 1'b0;
      standby   <= 1'b0;
      if (lastPrm)
      begin
        selDrive <= (cmd == CMD_SENSE_DRV || cmd == CMD_READ_ID) ? cmdData[1:0] : prmDrive;
        selHead  <= (cmd == CMD_SENSE_DRV || cmd == CMD_READ_ID) ? cmdData[BIT_HEAD]
                                                                 : prm[0][BIT_HEAD];
        case (cmd)
          CMD_SPECIFY:   cfg.specB   <= cmdData;
          CMD_CONFIGURE: cfg.preTrk  <= cmdData;
          CMD_PERP:      cfg.perp    <= cmdData;
          CMD_SEEK:
          begin
            seekReq   <= 1'b1;
            seekCyl   <= cmdData;
            seekDrive <= prmDrive;
          end
          CMD_REL_SEEK:
          begin
            seekReq   <= 1'b1;
            seekCyl   <= relTarget;
            seekDrive <= prmDrive;
          end
          default: ;
        endcase
      end
      if (takePrm && prmIdx == 2'd0 && cmd == CMD_SPECIFY)
        cfg.specA <= cmdData;
      if (takePrm && prmIdx == 2'd1 && cmd == CMD_CONFIGURE)
        cfg.cfgByte <= cmdData;
      if (takeCmd && newCmd == CMD_LOCK)
        cfg.lock <= cmdData[BIT_LOCK];
      if (takeCmd && newCmd == CMD_INVALID)
        standby <= 1'b1;
      if (needSeek)
      begin
        seekReq   <= 1'b1;
        seekCyl   <= xferCyl;
        seekDrive <= xferDrive;
      end
      if (xferDone)
        scEot <= xferScEot;
      if (seekDone)
        current_cylinder_position[seekDrive] <= seekCyl;
      if (lastPrm && cmd == CMD_READ_ID)
        readIdReq <= 1'b1;
      // a seek end arriving with the clear keeps the interrupt pending
      if (seekDone)
      begin
        intPending <= 1'b1;
        intSt0     <= seekSt0;
      end
      else if (intClear)
        intPending <= 1'b0;
      if (state == ST_EXEC)
      begin
        for (int i = 0; i < RES_DEPTH; i++)
          res[i] <= BYTE_ZERO;
        resCount <= RES_ONE;
        case (cmd)
          CMD_SENSE_INT:
            if (intPending)
            begin
              res[0]   <= intSt0;
              res[1]   <= current_cylinder_position[intSt0[1:0]];
              resCount <= RES_SENSE_INT;
            end
            else
              res[0] <= ST0_INVALID;
          CMD_SENSE_DRV: res[0] <= driveState;
          CMD_LOCK:      res[0] <= lockEcho;
          CMD_READ_ID:
          begin
            {res[0], res[1], res[2], res[3], res[4], res[5], res[6]} <= idInfo;
            resCount <= RES_READ_ID;
          end
          CMD_DUMP:
          begin
            for (int i = 0; i < NUM_DRIVES; i++)
              res[i] <= current_cylinder_position[i];
            res[4]   <= cfg.specA;
            res[5]   <= cfg.specB;
            res[6]   <= scEot;
            res[7]   <= {cfg.lock, cfg.perp[6:0]};
            res[8]   <= cfg.cfgByte;
            res[9]   <= cfg.preTrk;
            resCount <= RES_DUMP;
          end
          default: res[0] <= ST0_INVALID;
        endcase
      end
    end
  end

  // ****************************************************************
  // host facing outputs, all registered
  // ****************************************************************
  wire logic [3:0] next_resIdx = (state == ST_RESULT && resultRead) ? resIdx + 4'd1 : resIdx;
  wire logic       showRes     = (state == ST_RESULT) && !lastRes;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      resultByte    <= BYTE_ZERO;
      resultValid   <= 1'b0;
      cmdReady      <= 1'b0;
      impliedSeekEn <= 1'b0;
    end
    else
    begin
      // valid waits for the loaded buffer, and the byte stands until it is read
      resultValid   <= showRes;
      resultByte    <= showRes ? res[next_resIdx] : BYTE_ZERO;
      cmdReady      <= (state == ST_IDLE && !cmdWrite) || lastRes;
      impliedSeekEn <= cfg.cfgByte[BIT_DIR];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_invalid_result: assert property (@(posedge mclk) disable iff (reset)
    takeCmd && newCmd == CMD_INVALID |-> ##3 resultValid && resultByte == ST0_INVALID)
    else $error("invalid command did not answer 80h");
  a_invalid_standby: assert property (@(posedge mclk) disable iff (reset)
    takeCmd && newCmd == CMD_INVALID |=> standby)
    else $error("invalid command did not enter standby");
  a_drive_single: assert property (@(posedge mclk) disable iff (reset)
    state == ST_RESULT && cmd == CMD_SENSE_DRV |-> resCount == RES_ONE)
    else $error("sense drive result count wrong");
  a_sense_pair: assert property (@(posedge mclk) disable iff (reset)
    intClear |=> resCount == RES_SENSE_INT && res[0] == $past(intSt0))
    else $error("sense interrupt result mismatch");
  a_lock_echo: assert property (@(posedge mclk) disable iff (reset)
    state == ST_RESULT && cmd == CMD_LOCK |-> res[0] == {3'b000, cfg.lock, 4'b0000})
    else $error("lock echo wrong");
  a_read_id_wait: assert property (@(posedge mclk) disable iff (reset)
    state == ST_EXEC && cmd == CMD_READ_ID && !idValid |=> state == ST_EXEC)
    else $error("read id left execution without id");
  a_read_id_res: assert property (@(posedge mclk) disable iff (reset)
    state == ST_EXEC && cmd == CMD_READ_ID && idValid |=> resCount == RES_READ_ID
      && res[3] == $past(idInfo.cyl) && res[6] == $past(idInfo.size))
    else $error("read id result mismatch");
  a_dump_sc_eot: assert property (@(posedge mclk) disable iff (reset)
    state == ST_EXEC && cmd == CMD_DUMP |=> res[6] == $past(scEot))
    else $error("dump shared byte mismatch");
  a_no_cmd_in_res: assert property (@(posedge mclk) disable iff (reset)
    state == ST_RESULT && !resultRead |=> state == ST_RESULT)
    else $error("result phase ended without read");
  a_implied_seek: assert property (@(posedge mclk) disable iff (reset)
    needSeek |=> seekReq && seekCyl == $past(xferCyl))
    else $error("implied seek not issued");
endmodule

/* tb/fcp_drive_model.sv */
`timescale 1ns/1ns
// ****************************************
// seek engine and read channel stand-in
// ****************************************
module fcp_drive_model
  import fcp_pkg::*;
(
  input  wire logic    mclk,
  input  wire logic    reset,
  input  wire logic    seekReq,
  input  wire logic    readIdReq,
  input  wire fcp_id_t idPlan,
  input  var int       delay,
  output logic         seekDone,
  output logic         seekOk,
  output logic         idValid,
  output fcp_id_t      idInfo
);
  int sCnt = -1;
  int iCnt = -1;

  initial
  begin
    seekDone = 1'b0;
    seekOk = 1'b0;
    idValid = 1'b0;
    idInfo = '0;
  end

  // id lines toggle outside the strobe so a late sample is caught
  always @(posedge mclk)
  begin
    seekDone <= (sCnt == 0);
    // long seeks report failure so the abnormal completion code is exercised
    seekOk <= (sCnt == 0) && (delay < 16);
    idValid <= (iCnt == 0);
    idInfo <= (iCnt == 0) ? idPlan : ~idInfo;
    sCnt <= reset ? -1 : seekReq ? delay : (sCnt >= 0 ? sCnt - 1 : -1);
    iCnt <= reset ? -1 : readIdReq ? delay : (iCnt >= 0 ? iCnt - 1 : -1);
  end
endmodule

/* tb/fcp_command_phases_test.sv */
`timescale 1ns/1ns
module fcp_command_phases_test
  import fcp_pkg::*;
;
  logic       mclk = 0, reset = 1, cmdWrite = 0, resultRead = 0;
  logic       xferStart = 0, xferDone = 0, xferWasFormat = 0;
  logic [7:0] cmdData = '0, driveState = '0, xferCyl = '0, xferScEot = '0;
  logic [1:0] xferDrive = '0;
  logic [7:0] resultByte, seekCyl;
  logic [1:0] seekDrive;
  logic       resultValid, cmdReady, standby, seekReq, seekDone, seekOk;
  logic       readIdReq, idValid, impliedSeekEn;
  fcp_id_t    idInfo, idPlan = '0;
  int         delay = 1, miscompares = 0, total_checks = 0;
  int         stbCnt = 0, skCnt = 0;
  logic [7:0] lastCyl;
  logic [1:0] lastDrv;

  fcp_command_phases dut_u (.mclk(mclk), .reset(reset), .cmdWrite(cmdWrite),
    .cmdData(cmdData), .resultRead(resultRead), .resultByte(resultByte),
    .resultValid(resultValid), .cmdReady(cmdReady), .standby(standby),
    .seekReq(seekReq), .seekCyl(seekCyl), .seekDrive(seekDrive),
    .seekDone(seekDone), .seekOk(seekOk), .driveState(driveState),
    .readIdReq(readIdReq), .idValid(idValid), .idInfo(idInfo),
    .xferStart(xferStart), .xferDrive(xferDrive), .xferCyl(xferCyl),
    .xferDone(xferDone), .xferWasFormat(xferWasFormat),
    .xferScEot(xferScEot), .impliedSeekEn(impliedSeekEn));

  fcp_drive_model model_u (.mclk(mclk), .reset(reset), .seekReq(seekReq),
    .readIdReq(readIdReq), .idPlan(idPlan), .delay(delay),
    .seekDone(seekDone), .seekOk(seekOk), .idValid(idValid), .idInfo(idInfo));

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  // pulses are counted at the falling edge, clear of update races
  always @(negedge mclk)
  begin
    stbCnt += (standby === 1'b1);
    if (seekReq === 1'b1)
    begin
      skCnt++;
      lastCyl = seekCyl;
      lastDrv = seekDrive;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    cmdWrite <= 1'b1;
    cmdData <= b;
    @(posedge mclk);
    cmdWrite <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] op, p1, p2, p3, input int n);
    int k;
    k = 0;
    @(negedge mclk);
    while (cmdReady !== 1'b1 && k < 200)
    begin
      @(negedge mclk);
      k++;
    end
    check({7'h0, cmdReady}, 8'h01);
    send(op);
    if (n > 0)
      send(p1);
    if (n > 1)
      send(p2);
    if (n > 2)
      send(p3);
  endtask

  task automatic take(output logic [7:0] b);
    int k;
    k = 0;
    @(negedge mclk);
    while (resultValid !== 1'b1 && k < 200)
    begin
      @(negedge mclk);
      k++;
    end
    // a slow host must still see the same byte
    repeat (2'($urandom)) @(negedge mclk);
    b = resultByte;
    @(posedge mclk);
    resultRead <= 1'b1;
    @(posedge mclk);
    resultRead <= 1'b0;
  endtask

  function automatic bit known(input logic [7:0] v);
    return v inside {OP_SENSE_INT, OP_SPECIFY, OP_SENSE_DRV, OP_CONFIGURE, OP_DUMP, OP_PERP}
      || (v & MASK_DIR_MFM) inside {OP_READ_ID, OP_SEEK, OP_REL_SEEK}
      || (v & MASK_LOCK) == OP_LOCK;
  endfunction

  initial
  begin
    #400000;
    miscompares++;
    complete_run();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    logic [7:0] b, c, r, s1, s2, cfg, pt, pp, ev;
    logic [7:0] current_cylinder_position [4];
    logic [1:0] d;
    int n;
    void'($urandom(32'h9f73));
    current_cylinder_position = '{default: 8'h00};
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(negedge mclk);
    check({7'h0, cmdReady}, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      cmd({i[0], 7'h14}, 0, 0, 0, 0);
      send(OP_SENSE_INT);
      take(b);
      check(b, {3'h0, i[0], 4'h0});
    end
    for (int i = 0; i < 4; i++)
    begin
      do c = 8'($urandom); while (known(c));
      n = stbCnt;
      cmd(c, 0, 0, 0, 0);
      take(b);
      check(b, ST0_INVALID);
      check(8'(stbCnt - n), 8'h01);
    end
    cmd(OP_SENSE_INT, 0, 0, 0, 0);
    take(b);
    check(b, ST0_INVALID);
    s1 = 8'($urandom);
    s2 = 8'($urandom);
    cmd(OP_SPECIFY, s1, s2, 0, 2);
    cfg = {2'b01, 6'($urandom)};
    pt = 8'($urandom);
    cmd(OP_CONFIGURE, 0, cfg, pt, 3);
    pp = {1'b0, 7'($urandom)};
    cmd(OP_PERP, pp, 0, 0, 1);
    check({7'h0, impliedSeekEn}, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      d = 2'($urandom);
      delay = i[0] ? 20 : 1;
      c = i[1] ? 8'($urandom % 64) : {1'b0, 7'($urandom)};
      r = i[1] ? current_cylinder_position[d] + c : c;
      // drive bits carry the random drive d, head bit follows i[1]
      cmd(i[1] ? 8'hCF : OP_SEEK, {5'h0, i[1], d}, c, 0, 2);
      repeat (40) @(negedge mclk);
      check(lastCyl, r);
      check({6'h0, lastDrv}, {6'h0, d});
      current_cylinder_position[d] = r;
      cmd(OP_SENSE_INT, 0, 0, 0, 0);
      take(b);
      check(b, {i[0] ? IC_ABNORMAL : IC_NORMAL, 1'b1, 2'b00, i[1], d});
      take(b);
      check(b, r);
    end
    driveState <= 8'($urandom);
    cmd(OP_SENSE_DRV, {5'h0, 1'b1, d}, 0, 0, 1);
    take(b);
    check(b, driveState);
    idPlan <= {$urandom, 24'($urandom)};
    cmd(OP_READ_ID, {6'h0, d}, 0, 0, 1);
    for (int k = 0; k < 7; k++)
    begin
      take(b);
      check(b, idPlan[55 - 8 * k -: 8]);
    end
    for (int f = 0; f < 2; f++)
    begin
      ev = 8'($urandom);
      @(posedge mclk);
      xferDone <= 1'b1;
      xferWasFormat <= f[0];
      xferScEot <= ev;
      @(posedge mclk);
      xferDone <= 1'b0;
      cmd(OP_DUMP, 0, 0, 0, 0);
      for (int k = 0; k < 4; k++)
      begin
        take(b);
        check(b, current_cylinder_position[k]);
      end
      take(b);
      check(b, s1);
      take(b);
      check(b, s2);
      take(b);
      check(b, ev);
      take(b);
      check(b, {1'b1, pp[6:0]});
      take(b);
      check(b, cfg);
      take(b);
      check(b, pt);
    end
    n = skCnt;
    @(posedge mclk);
    xferStart <= 1'b1;
    xferDrive <= d;
    xferCyl <= current_cylinder_position[d] + 8'h01;
    @(posedge mclk);
    xferStart <= 1'b0;
    repeat (30) @(negedge mclk);
    check(8'(skCnt - n), 8'h01);
    check(lastCyl, current_cylinder_position[d] + 8'h01);
    complete_run();
  end
endmodule
